//--- src/tcd_dma.sv
`timescale 1ns/1ns
`include "tcd_params.svh"

// Operation
// - ten independent channels, each with own source, addresses and counter
// - software write to the request register starts a channel transfer
// - hardware requests from converter, timer, serial receive and transmit
// - each channel runs up to 65536 transfers counted by its counter
// - addresses live in a fixed 64K window, only low 16 bits programmable
// - one grant moves one item, read then write, bus released after
// - source and destination each fixed, incrementing or 32-item ring
// - simultaneous requests granted by fixed priority, channel zero first
// - counter underflow sets completion flag and may raise shared interrupt
// - cascade chain zero to one, one to two, two to zero or three
// - cascade one transfer on three starts one on four
// - channel five starts when channel zero finishes whole run
// - cascade five to six, six to seven, seven to five or eight
// - cascade one transfer on eight starts one on nine
// - transfers between peripheral registers and RAM in any combination
// - one item completes about every three clocks with zero-wait bus
module tcd_dma
    import tcd_pkg::*;
(
    // clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   srst_i,
    // register bus slave
    input  wire logic [`TCD_ADR_W-1:0]  avs_address_i,
    input  wire logic                   avs_read_i,
    input  wire logic                   avs_write_i,
    input  wire logic [31:0]            avs_writedata_i,
    output logic      [31:0]            avs_readdata_o,
    output logic                        avs_waitrequest_o,
    // peripheral request pulses
    input  wire logic                   adc_req_i,
    input  wire logic                   tmr_req_i,
    input  wire logic                   sio_rx_req_i,
    input  wire logic                   sio_tx_req_i,
    // internal bus master
    output tcd_mem_req_s                mem_req_o,
    input  wire logic                   mem_ack_i,
    input  wire logic [15:0]            mem_rdata_i,
    // interrupt
    output logic                        irq_o
);

    // lowest numbered pending channel wins
    function automatic tcd_chidx_t prio_pick(input tcd_vec_t p);
        tcd_chidx_t r;
        r = 4'h0;
        for (int i = `TCD_NCH - 1; i >= 0; i--) begin
            if (p[i]) begin
                r = tcd_chidx_t'(i);
            end
        end
        return r;
    endfunction : prio_pick

    // which channel's single transfer feeds each channel's cascade input
    function automatic int casc_src(input int i);
        int r;
        r = 0;
        case (i)
            0: r = 2;
            1: r = 0;
            2: r = 1;
            3: r = 2;
            4: r = 3;
            5: r = 7;
            6: r = 5;
            7: r = 6;
            8: r = 7;
            9: r = 8;
            default: r = 0;
        endcase
        return r;
    endfunction : casc_src

    // address update; ring wraps the low bits over 32 item positions
    function automatic logic [15:0] next_addr(
        input logic [15:0] a,
        input logic [1:0]  mode,
        input logic        sz16
    );
        logic [15:0] inc;
        logic [15:0] wmask;
        inc   = a + (sz16 ? `TCD_STEP16 : `TCD_STEP8);
        wmask = sz16 ? `TCD_RING_MASK16 : `TCD_RING_MASK8;
        if (mode == `TCD_AM_INC) begin
            return inc;
        end else if (mode == `TCD_AM_RING) begin
            return (a & ~wmask) | (inc & wmask);
        end
        return a;
    endfunction : next_addr

    // state
    tcd_cfg_s     cfg_r [`TCD_NCH];
    logic [15:0]  src_r [`TCD_NCH];
    logic [15:0]  dst_r [`TCD_NCH];
    logic [15:0]  cnt_r [`TCD_NCH];
    tcd_vec_t     pend_r;
    tcd_vec_t     pend_nxt;
    tcd_vec_t     status_r;
    tcd_vec_t     status_nxt;
    tcd_vec_t     mask_r;
    tcd_state_e   st_r;
    tcd_chidx_t   cur_r;
    tcd_mem_req_s mem_r;
    logic         wait_r;
    logic [31:0]  rdata_r;
    logic         irq_r;

    // bus handshake: one wait cycle, then the access completes
    wire logic        req_w     = avs_read_i | avs_write_i;
    wire logic        wr_fire_w = avs_write_i & ~wait_r;
    wire logic        rd_fire_w = avs_read_i & ~wait_r;
    wire logic        rd_take_w = avs_read_i & wait_r;

    // address decode
    wire logic        is_glb_w  = avs_address_i[`TCD_ADR_GLB];
    wire tcd_chidx_t  ch_a_w    = avs_address_i[`TCD_ADR_CH];
    wire logic [1:0]  sel_w     = avs_address_i[`TCD_ADR_SEL];
    wire logic        ch_ok_w   = ~is_glb_w & (ch_a_w < `TCD_NCH_W);
    wire logic        glb_ok_w  = is_glb_w & (ch_a_w == 4'h0);
    wire tcd_chidx_t  ch_i_w    = ch_ok_w ? ch_a_w : 4'h0;

    // global register strobes
    wire logic        w_sw_w    = wr_fire_w & glb_ok_w & (sel_w == `TCD_SEL_SWREQ);
    wire logic        w_mask_w  = wr_fire_w & glb_ok_w & (sel_w == `TCD_SEL_MASK);
    wire logic        r_stat_w  = rd_fire_w & glb_ok_w & (sel_w == `TCD_SEL_STATUS);

    // transfer completion events
    wire logic        done_w    = (st_r == S_WR) & mem_ack_i;
    wire logic [15:0] cur_cnt_w = cnt_r[cur_r];
    wire logic        uf_w      = done_w & (cur_cnt_w == `TCD_RST_WORD);
    wire tcd_vec_t    done_oh_w = done_w ? (10'h001 << cur_r) : `TCD_RST_VEC;
    wire tcd_vec_t    uf_oh_w   = uf_w ? (10'h001 << cur_r) : `TCD_RST_VEC;

    // software request vector, only channels 0..9 used
    wire tcd_vec_t    sw_w      = w_sw_w ? avs_writedata_i[9:0] : `TCD_RST_VEC;

    // arbitration
    wire tcd_chidx_t  win_w     = prio_pick(pend_r);
    wire logic        grant_w   = (st_r == S_IDLE) & (|pend_r);
    wire tcd_vec_t    grant_oh_w = grant_w ? (10'h001 << win_w) : `TCD_RST_VEC;

    tcd_vec_t         trig_w;
    tcd_vec_t         en_w;

    // per-channel registers and request selection
    for (genvar g = 0; g < `TCD_NCH; g++) begin : g_ch
        wire logic     sel_me_w = ch_ok_w & (ch_a_w == tcd_chidx_t'(g));
        wire logic     w_cfg_w  = wr_fire_w & sel_me_w & (sel_w == `TCD_SEL_CFG);
        wire logic     w_src_w  = wr_fire_w & sel_me_w & (sel_w == `TCD_SEL_SRC);
        wire logic     w_dst_w  = wr_fire_w & sel_me_w & (sel_w == `TCD_SEL_DST);
        wire logic     w_cnt_w  = wr_fire_w & sel_me_w & (sel_w == `TCD_SEL_CNT);
        wire logic     me_w     = done_oh_w[g];
        wire logic [2:0] rs_w   = cfg_r[g].req_sel;
        wire logic     casc_w   = done_oh_w[casc_src(g)];
        // only channel five listens to the end of channel zero's run
        wire logic     runend_w = (g == `TCD_RUNEND_DST) ? uf_oh_w[`TCD_RUNEND_SRC]
                                                         : 1'b0;

        assign en_w[g]   = cfg_r[g].en;
        assign trig_w[g] = cfg_r[g].en & (sw_w[g]
                         | ((rs_w == `TCD_RS_ADC)    & adc_req_i)
                         | ((rs_w == `TCD_RS_TMR)    & tmr_req_i)
                         | ((rs_w == `TCD_RS_SIO_RX) & sio_rx_req_i)
                         | ((rs_w == `TCD_RS_SIO_TX) & sio_tx_req_i)
                         | ((rs_w == `TCD_RS_CASC)   & casc_w)
                         | ((rs_w == `TCD_RS_RUNEND) & runend_w));

        // configuration; underflow drops the enable so the run stops
        always_ff @(posedge core_clk_i) begin
            if (srst_i) begin
                cfg_r[g] <= tcd_cfg_s'(`TCD_RST_CFG);
            end else if (w_cfg_w) begin
                cfg_r[g] <= tcd_cfg_s'(avs_writedata_i[8:0]);
            end else if (me_w && uf_w) begin
                cfg_r[g].en <= 1'b0;
            end
        end

        // addresses step after each item, software writes take precedence
        always_ff @(posedge core_clk_i) begin
            if (srst_i) begin
                src_r[g] <= `TCD_RST_WORD;
                dst_r[g] <= `TCD_RST_WORD;
            end else begin
                if (w_src_w) begin
                    src_r[g] <= avs_writedata_i[15:0];
                end else if (me_w) begin
                    src_r[g] <= next_addr(src_r[g], cfg_r[g].src_mode, cfg_r[g].size16);
                end
                if (w_dst_w) begin
                    dst_r[g] <= avs_writedata_i[15:0];
                end else if (me_w) begin
                    dst_r[g] <= next_addr(dst_r[g], cfg_r[g].dst_mode, cfg_r[g].size16);
                end
            end
        end

        // count holds transfers left minus one; 16'hFFFF gives a full 65536 run
        always_ff @(posedge core_clk_i) begin
            if (srst_i) begin
                cnt_r[g] <= `TCD_RST_WORD;
            end else if (w_cnt_w) begin
                cnt_r[g] <= avs_writedata_i[15:0];
            end else if (me_w) begin
                cnt_r[g] <= cnt_r[g] - 16'h0001;
            end
        end
    end

    // pending: set wins over grant clear, repeats merge into one request;
    // a run that ends drops any request queued behind its last item
    assign pend_nxt = ((pend_r & ~grant_oh_w) | trig_w) & en_w & ~uf_oh_w;

    // completion flags: the read clears only the bits it reported, so a flag
    // raised between capture and completion survives; set wins over the clear
    assign status_nxt = (status_r & ~(r_stat_w ? rdata_r[9:0] : `TCD_RST_VEC))
                      | uf_oh_w;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pend_r   <= `TCD_RST_VEC;
            status_r <= `TCD_RST_VEC;
            mask_r   <= `TCD_RST_VEC;
            irq_r    <= 1'b0;
        end else begin
            pend_r   <= pend_nxt;
            status_r <= status_nxt;
            mask_r   <= w_mask_w ? avs_writedata_i[9:0] : mask_r;
            irq_r    <= |(status_r & mask_r);
        end
    end

    // sequencer: idle/grant, read, write; zero-wait bus gives three clocks per item
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_r  <= S_IDLE;
            cur_r <= 4'h0;
            mem_r <= '0;
        end else begin
            unique case (st_r)
                S_IDLE: begin
                    if (grant_w) begin
                        st_r         <= S_RD;
                        cur_r        <= win_w;
                        mem_r.addr   <= {`TCD_WIN_BASE, src_r[win_w]};
                        mem_r.rd     <= 1'b1;
                        mem_r.size16 <= cfg_r[win_w].size16;
                    end
                end
                S_RD: begin
                    if (mem_ack_i) begin
                        st_r        <= S_WR;
                        mem_r.rd    <= 1'b0;
                        mem_r.wr    <= 1'b1;
                        mem_r.addr  <= {`TCD_WIN_BASE, dst_r[cur_r]};
                        mem_r.wdata <= mem_rdata_i;
                    end
                end
                S_WR: begin
                    if (mem_ack_i) begin
                        st_r     <= S_IDLE;
                        mem_r.wr <= 1'b0;
                    end
                end
                default: begin
                    st_r  <= S_IDLE;
                    mem_r <= '0;
                end
            endcase
        end
    end

    // read data selection
    wire logic [31:0] ch_rd_w =
        (sel_w == `TCD_SEL_CFG) ? {23'h000000, cfg_r[ch_i_w]} :
        (sel_w == `TCD_SEL_SRC) ? {16'h0000, src_r[ch_i_w]} :
        (sel_w == `TCD_SEL_DST) ? {16'h0000, dst_r[ch_i_w]} :
                                  {16'h0000, cnt_r[ch_i_w]};
    wire logic [31:0] glb_rd_w =
        (sel_w == `TCD_SEL_SWREQ)  ? {22'h000000, pend_r} :
        (sel_w == `TCD_SEL_STATUS) ? {22'h000000, status_r} :
        (sel_w == `TCD_SEL_MASK)   ? {22'h000000, mask_r} :
                                     {27'h0000000, (st_r != S_IDLE), cur_r};
    wire logic [31:0] rd_mux_w = ch_ok_w  ? ch_rd_w :
                                 glb_ok_w ? glb_rd_w : 32'h00000000;

    // waitrequest drops for one cycle per access; read data captured alongside
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h00000000;
        end else begin
            wait_r  <= ~(req_w & wait_r);
            rdata_r <= rd_take_w ? rd_mux_w : rdata_r;
        end
    end

    assign avs_waitrequest_o = wait_r;
    assign avs_readdata_o    = rdata_r;
    assign mem_req_o         = mem_r;
    assign irq_o             = irq_r;

    // assertions
    a_prio_grant: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (st_r == S_IDLE && |pend_r) |=> (st_r == S_RD && cur_r == $past(win_w)))
        else $error("grant went to the wrong channel");

    a_item_order: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (st_r == S_RD && mem_ack_i) |=>
        (mem_r.wr && !mem_r.rd && mem_r.wdata == $past(mem_rdata_i)))
        else $error("write did not follow read with read data");

    a_bus_release: assert property (@(posedge core_clk_i) disable iff (srst_i)
        done_w |=> (!mem_r.rd && !mem_r.wr && st_r == S_IDLE))
        else $error("bus not released after an item");

    a_addr_window: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (mem_r.rd || mem_r.wr) |-> mem_r.addr[31:16] == `TCD_WIN_BASE)
        else $error("address outside the transfer window");

    a_count_step: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (done_w && !uf_w && !wr_fire_w) |=>
        cnt_r[$past(cur_r)] == $past(cur_cnt_w) - 16'h0001)
        else $error("counter did not step by one");

    a_uf_stop: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (uf_w && !wr_fire_w) |=> (status_r[$past(cur_r)] && !cfg_r[$past(cur_r)].en))
        else $error("underflow did not flag and stop the channel");

    a_casc_zero: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (done_w && cur_r == 4'h0 && cfg_r[1].en && cfg_r[1].req_sel == `TCD_RS_CASC
         && !wr_fire_w) |=> pend_r[1])
        else $error("cascade from channel zero lost");

    a_sw_pend: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (|(sw_w & en_w & ~uf_oh_w)) |=>
        ((pend_r & $past(sw_w & en_w & ~uf_oh_w)) == $past(sw_w & en_w & ~uf_oh_w)))
        else $error("software request not pending");

    a_irq_level: assert property (@(posedge core_clk_i) disable iff (srst_i)
        ((status_r & mask_r) != `TCD_RST_VEC) |=> irq_o)
        else $error("unmasked flag did not raise interrupt");

    a_item_rate: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (st_r == S_IDLE && |pend_r) ##1 mem_ack_i ##1 mem_ack_i |-> done_w)
        else $error("item took more than three clocks");

    a_flag_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !r_stat_w |=> ((status_r & $past(status_r)) == $past(status_r)))
        else $error("completion flag dropped without a read");

    a_read_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (r_stat_w && uf_oh_w == `TCD_RST_VEC) |=>
        ((status_r & $past(rdata_r[9:0])) == `TCD_RST_VEC))
        else $error("reported flags not cleared by the read");

    a_pend_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (|(pend_r & ~grant_oh_w & en_w & ~uf_oh_w)) |=>
        ((pend_r & $past(pend_r & ~grant_oh_w & en_w & ~uf_oh_w))
         == $past(pend_r & ~grant_oh_w & en_w & ~uf_oh_w)))
        else $error("waiting request lost");

    a_stop_clean: assert property (@(posedge core_clk_i) disable iff (srst_i)
        uf_w |=> !pend_r[$past(cur_r)])
        else $error("request survived the end of the run");

    a_irq_drop: assert property (@(posedge core_clk_i) disable iff (srst_i)
        ((status_r & mask_r) == `TCD_RST_VEC) |=> !irq_o)
        else $error("interrupt stayed high with no unmasked flag");

endmodule : tcd_dma

//--- src/tcd_params.svh
`ifndef TCD_PARAMS_SVH
`define TCD_PARAMS_SVH

// channel count and address window
`define TCD_NCH          10
`define TCD_NCH_W        4'hA
`define TCD_WIN_BASE     16'h0080

// register bus layout (byte addresses, one word each)
`define TCD_ADR_W        9
`define TCD_ADR_GLB      8
`define TCD_ADR_CH       7:4
`define TCD_ADR_SEL      3:2
`define TCD_SEL_CFG      2'h0
`define TCD_SEL_SRC      2'h1
`define TCD_SEL_DST      2'h2
`define TCD_SEL_CNT      2'h3
`define TCD_SEL_SWREQ    2'h0
`define TCD_SEL_STATUS   2'h1
`define TCD_SEL_MASK     2'h2
`define TCD_SEL_BUSY     2'h3

// address behaviours
`define TCD_AM_FIXED     2'h0
`define TCD_AM_INC       2'h1
`define TCD_AM_RING      2'h2
`define TCD_STEP8        16'h0001
`define TCD_STEP16       16'h0002
`define TCD_RING_MASK8   16'h001F
`define TCD_RING_MASK16  16'h003F

// request source selection codes
`define TCD_RS_SW        3'h0
`define TCD_RS_ADC       3'h1
`define TCD_RS_TMR       3'h2
`define TCD_RS_SIO_RX    3'h3
`define TCD_RS_SIO_TX    3'h4
`define TCD_RS_CASC      3'h5
`define TCD_RS_RUNEND    3'h6

// run-end cascade: target channel and source channel
`define TCD_RUNEND_DST   5
`define TCD_RUNEND_SRC   0

// reset values
`define TCD_RST_CFG      9'h000
`define TCD_RST_WORD     16'h0000
`define TCD_RST_VEC      10'h000

`endif

//--- src/tcd_pkg.sv
package tcd_pkg;

    // transfer sequencer states
    typedef enum logic [1:0] {
        S_IDLE,
        S_RD,
        S_WR
    } tcd_state_e;

    // per-channel configuration word, bit 0 is the enable
    typedef struct packed {
        logic [2:0] req_sel;
        logic [1:0] dst_mode;
        logic [1:0] src_mode;
        logic       size16;
        logic       en;
    } tcd_cfg_s;

    // request to the internal bus
    typedef struct packed {
        logic [31:0] addr;
        logic        rd;
        logic        wr;
        logic        size16;
        logic [15:0] wdata;
    } tcd_mem_req_s;

    typedef logic [3:0] tcd_chidx_t;
    typedef logic [9:0] tcd_vec_t;

endpackage : tcd_pkg

//--- test/tcd_dma_test.sv
`timescale 1ns/1ns
`include "tcd_params.svh"
module tcd_dma_test
    import tcd_pkg::*;
;
    logic         core_clk = 1'b0;
    logic         srst = 1'b1;
    logic [8:0]   adr = 9'h000;
    logic         rd = 1'b0;
    logic         wr = 1'b0;
    logic [31:0]  wdat = 32'h0;
    logic [3:0]   hw = 4'h0;
    logic [3:0]   wcyc = 4'h0;
    wire  [31:0]  rdat;
    wire          wreq;
    wire          ack;
    wire  [15:0]  mrd;
    wire          irq;
    tcd_mem_req_s mreq;
    int           err_count = 0;
    int           total_checks = 0;
    int           cyc = 0;
    logic [15:0]  rq[$];
    logic [15:0]  wq[$];
    int           rt[$];
    logic [31:0]  q;

    tcd_dma u_tcd_dma (.core_clk_i(core_clk), .srst_i(srst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .adc_req_i(hw[0]),
        .tmr_req_i(hw[1]), .sio_rx_req_i(hw[2]), .sio_tx_req_i(hw[3]),
        .mem_req_o(mreq), .mem_ack_i(ack), .mem_rdata_i(mrd), .irq_o(irq));
    tcd_mem_model u_tcd_mem_model (.core_clk_i(core_clk), .srst_i(srst),
        .mem_req_i(mreq), .wait_cyc_i(wcyc), .mem_ack_o(ack), .mem_rdata_o(mrd));

    // 50 MHz clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // log every completed read and write address, reads also with their cycle
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (ack && (mreq.rd || mreq.wr)) begin
            check("window", {16'h0, mreq.addr[31:16]}, {16'h0, `TCD_WIN_BASE});
            if (mreq.rd) begin
                rq.push_back(mreq.addr[15:0]);
                rt.push_back(cyc);
            end else begin
                wq.push_back(mreq.addr[15:0]);
            end
        end
    end

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one avalon access; the request holds until waitrequest is sampled low
    task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge core_clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50)
            check("waitrequest", 32'h1, 32'h0);
    endtask : bus

    task rdc(input string nm, input logic [8:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(nm, q, e);
    endtask : rdc

    function automatic logic [8:0] cf(logic [2:0] s, logic [1:0] dm, logic [1:0] sm, logic w);
        tcd_cfg_s c = '{s, dm, sm, w, 1'b1};
        return c;
    endfunction : cf

    task setup(input int ch, input logic [8:0] c, input logic [15:0] s, d, n);
        bus(1'b1, 9'(ch * 16), {23'h0, c});
        bus(1'b1, 9'(ch * 16 + 4), {16'h0, s});
        bus(1'b1, 9'(ch * 16 + 8), {16'h0, d});
        bus(1'b1, 9'(ch * 16 + 12), {16'h0, n});
    endtask : setup

    // bounded wait for n items, then a few cycles for counters and flags to land
    task wait_wr(input int n);
        int k;
        k = 0;
        while (wq.size() < n && k < 400) begin
            @(posedge core_clk);
            k++;
        end
        repeat (6) @(posedge core_clk);
        check("items", 32'(wq.size()), 32'(n));
    endtask : wait_wr

    task clr();
        rq.delete();
        wq.delete();
        rt.delete();
    endtask : clr

    task pulse(input int k);
        @(posedge core_clk);
        hw[k] <= 1'b1;
        @(posedge core_clk);
        hw[k] <= 1'b0;
    endtask : pulse

    task t_reset();
        rdc("cfg0", 9'h000, 32'h0);
        rdc("cnt9", 9'h09C, 32'h0);
        rdc("busy", 9'h10C, 32'h0);
        bus(1'b1, 9'h1F0, 32'hFFFF_FFFF);
        rdc("unmapped", 9'h1F0, 32'h0);
        check("irq idle", irq, 1'b0);
    endtask : t_reset

    // two software items, underflow stops the channel, flag and interrupt
    task t_sw_irq();
        clr();
        setup(3, cf(`TCD_RS_SW, `TCD_AM_INC, `TCD_AM_INC, 1'b1), 16'h4000, 16'h5000, 16'h1);
        bus(1'b1, 9'h100, 32'h8);
        bus(1'b1, 9'h100, 32'h8);
        wait_wr(2);
        check("dst step", wq[1], 16'h5002);
        check("data", u_tcd_mem_model.mem[16'h5002], 16'h4002 ^ 16'h5A3C);
        rdc("cnt", 9'h03C, 32'hFFFF);
        rdc("cfg", 9'h030, {23'h0, 9'h016});
        check("irq masked", irq, 1'b0);
        bus(1'b1, 9'h108, 32'h8);
        repeat (2) @(posedge core_clk);
        check("irq", irq, 1'b1);
        rdc("status", 9'h104, 32'h8);
        repeat (2) @(posedge core_clk);
        check("irq cleared", irq, 1'b0);
        bus(1'b1, 9'h100, 32'h8);
        wait_wr(2);
        bus(1'b1, 9'h108, 32'h0);
    endtask : t_sw_irq

    task t_prio();
        clr();
        setup(9, cf(`TCD_RS_SW, `TCD_AM_INC, `TCD_AM_INC, 1'b1), 16'h9100, 16'h9800, 16'hFF);
        setup(0, cf(`TCD_RS_SW, `TCD_AM_INC, `TCD_AM_INC, 1'b1), 16'h0100, 16'h0800, 16'hFF);
        bus(1'b1, 9'h100, 32'h201);
        wait_wr(2);
        check("first", rq[0], 16'h0100);
        check("second", rq[1], 16'h9100);
        check("period", 32'(rt[1] - rt[0]), 32'd3);
    endtask : t_prio

    // each source once, preceded by a pulse of a source not selected
    task t_hw();
        for (int k = 0; k < 4; k++) begin
            clr();
            setup(4, cf(3'(`TCD_RS_ADC + k), `TCD_AM_FIXED, `TCD_AM_FIXED, 1'b1),
                  16'h6000, 16'h6100, 16'hFF);
            pulse((k + 1) % 4);
            pulse(k);
            wait_wr(1);
        end
    endtask : t_hw

    // cascade walk over all ten channels, channel five started by run end
    task t_casc();
        wcyc <= 4'h2;
        clr();
        for (int n = 0; n < 10; n++) begin
            setup(n, cf(n == 0 ? `TCD_RS_SW : (n == 5 ? `TCD_RS_RUNEND : `TCD_RS_CASC),
                  `TCD_AM_INC, `TCD_AM_INC, 1'b1), {4'(n), 12'h200}, {4'(n), 12'h600},
                  n == 0 ? 16'h0 : 16'h10);
        end
        bus(1'b1, 9'h100, 32'h1);
        wait_wr(10);
        for (int n = 0; n < 10; n++) begin
            check("cascade", rq[n], {4'(n), 12'h200});
        end
        // leave the chain idle so later single-channel tests see no cascades
        for (int n = 1; n < 10; n++) begin
            bus(1'b1, 9'(n * 16), 32'h0);
        end
        wcyc <= 4'h0;
    endtask : t_casc

    task t_ring();
        logic [15:0] exp_a[4] = '{16'h201E, 16'h201F, 16'h2000, 16'h2001};
        clr();
        setup(6, cf(`TCD_RS_SW, `TCD_AM_FIXED, `TCD_AM_RING, 1'b0), 16'h201E, 16'h3000, 16'h3);
        repeat (4) bus(1'b1, 9'h100, 32'h40);
        wait_wr(4);
        for (int i = 0; i < 4; i++) begin
            check("ring src", rq[i], exp_a[i]);
        end
        check("fixed dst", wq[3], 16'h3000);
        rdc("src", 9'h064, 32'h2002);
    endtask : t_ring

    // slow bus: repeated requests for a waiting channel merge into one
    task t_merge();
        wcyc <= 4'h6;
        clr();
        setup(2, cf(`TCD_RS_SW, `TCD_AM_INC, `TCD_AM_INC, 1'b1), 16'h7000, 16'h7100, 16'hFF);
        setup(3, cf(`TCD_RS_SW, `TCD_AM_INC, `TCD_AM_INC, 1'b1), 16'h7200, 16'h7300, 16'hFF);
        bus(1'b1, 9'h100, 32'h4);
        bus(1'b1, 9'h100, 32'h8);
        bus(1'b1, 9'h100, 32'h8);
        wait_wr(2);
        check("held", rq[1], 16'h7200);
        repeat (20) @(posedge core_clk);
        check("merged", 32'(wq.size()), 32'd2);
        wcyc <= 4'h0;
    endtask : t_merge

    task end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        end_of_test();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        t_reset();
        t_sw_irq();
        t_prio();
        t_hw();
        t_casc();
        t_ring();
        t_merge();
        end_of_test();
    end
endmodule : tcd_dma_test

//--- test/tcd_mem_model.sv
`timescale 1ns/1ns
// behavioural internal bus: peripheral registers and ram share one 64K window
module tcd_mem_model
    import tcd_pkg::*;
(
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         srst_i,
    // bus from the controller
    input  wire tcd_mem_req_s mem_req_i,
    input  wire logic [3:0]   wait_cyc_i,
    output logic              mem_ack_o,
    output logic [15:0]       mem_rdata_o
);
    logic [15:0] mem [0:65535];
    logic [3:0]  cnt_r = 4'h0;
    logic [15:0] junk_r = 16'hC3C3;
    wire         req_w = mem_req_i.rd | mem_req_i.wr;

    // each location starts with a pattern of its own address
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 16'(i) ^ 16'h5A3C;
        end
    end

    // answer after wait_cyc_i cycles; read data is junk away from the ack
    assign mem_ack_o   = req_w && (cnt_r == wait_cyc_i);
    assign mem_rdata_o = (mem_ack_o && mem_req_i.rd) ? mem[mem_req_i.addr[15:0]] : junk_r;

    // wait counter restarts per access so every read and write is slowed alike
    always @(posedge core_clk_i) begin
        junk_r <= junk_r + 16'h3B1D;
        if (srst_i || mem_ack_o || !req_w)
            cnt_r <= 4'h0;
        else
            cnt_r <= cnt_r + 4'h1;
        if (mem_ack_o && mem_req_i.wr)
            mem[mem_req_i.addr[15:0]] <= mem_req_i.wdata;
    end
endmodule : tcd_mem_model
